// *** servo_stop_pkg.sv ***
/*
 * Indices, reset values, codes and types of the stop/homing block.
 * Assumes one clock and object access by index and sub-index.
 */
package servo_stop_pkg;

   // Object indices and sub-indices
   localparam logic [15:0] IDX_QS_DECEL      = 16'h6085;
   localparam logic [15:0] IDX_PROFILE_TYPE  = 16'h6086;
   localparam logic [15:0] IDX_TORQUE_SLOPE  = 16'h6087;
   localparam logic [15:0] IDX_HOME_METHOD   = 16'h6098;
   localparam logic [15:0] IDX_HOME_SPEEDS   = 16'h6099;
   localparam logic [7:0]  SUB_COUNT         = 8'h00;
   localparam logic [7:0]  SUB_SWITCH_SPEED  = 8'h01;
   localparam logic [7:0]  SUB_ZERO_SPEED    = 8'h02;
   localparam logic [7:0]  HOME_SPEED_COUNT  = 8'h02;

   // Reset values
   localparam logic [31:0] QS_DECEL_RST      = 32'h7FFFFFFF;
   localparam logic [15:0] PROFILE_TYPE_RST  = 16'h0000;
   localparam logic [15:0] PROFILE_LINEAR    = 16'h0000;
   localparam logic [31:0] TORQUE_SLOPE_RST  = 32'hFFFFFFFF;
   localparam logic [7:0]  HOME_METHOD_RST   = 8'h01;
   localparam logic [31:0] SWITCH_SPEED_RST  = 32'h00000064;
   localparam logic [31:0] ZERO_SPEED_RST    = 32'h0000000A;
   localparam logic [31:0] ZERO_SUBSTITUTE   = 32'h00000001;

   // Control word and option codes
   localparam logic [15:0] CW_QUICK_STOP     = 16'h0002;
   localparam logic [15:0] OPT_CODE_1        = 16'h0001;
   localparam logic [15:0] OPT_CODE_2        = 16'h0002;
   localparam logic [15:0] OPT_CODE_5        = 16'h0005;
   localparam logic [15:0] OPT_CODE_6        = 16'h0006;

   // Homing method codes
   localparam logic [7:0]  METHOD_MAX        = 8'h23;
   localparam logic [7:0]  METHOD_STD_FIRST  = 8'h01;
   localparam logic [7:0]  METHOD_STD_LAST   = 8'h0E;
   localparam logic [7:0]  METHOD_CO_FIRST   = 8'h11;
   localparam logic [7:0]  METHOD_CO_LAST    = 8'h1E;
   localparam logic [7:0]  METHOD_CO_OFFSET  = 8'h10;
   localparam logic [7:0]  METHOD_INDEX_REV  = 8'h21;
   localparam logic [7:0]  METHOD_INDEX_FWD  = 8'h22;
   localparam logic [7:0]  METHOD_HERE       = 8'h23;
   // Bit n set: method n+1 searches forward
   localparam logic [13:0] HOME_FWD_MASK     = 14'h03E2;

   // Kind of homing run chosen from the method code
   typedef enum logic [2:0] {
      KIND_NONE     = 3'h0,
      KIND_STD      = 3'h1,
      KIND_COINCIDE = 3'h2,
      KIND_INDEX    = 3'h3,
      KIND_HERE     = 3'h4
   } home_kind_t;

   // Homing sequencer states
   typedef enum logic [5:0] {
      ST_IDLE       = 6'b000001,
      ST_SEEK_DEC   = 6'b000010,
      ST_DECEL      = 6'b000100,
      ST_SEEK_HOME  = 6'b001000,
      ST_SEEK_INDEX = 6'b010000,
      ST_DONE       = 6'b100000
   } home_state_t;

endpackage

// *** homing_if.sv ***
/*
 * Carrier from the parameter block to the homing sequencer.
 * Assumes both ends on clk_in, pins already synchronised.
 */
`timescale 1ns/1ps
interface homing_if;
   import servo_stop_pkg::*;

   // Command side
   logic       start;
   logic       abort;
   home_kind_t kind;
   // Synchronised pin levels and same-clock slow-down done level
   logic       decel_sw;
   logic       home_sw;
   logic       index_p;
   logic       decel_done;
   // Sequencer status
   logic       busy;
   logic       done;
   logic       sel_zero;
   logic       mask_home;

   modport ctrl (output start, abort, kind, decel_sw, home_sw,
                 index_p, decel_done,
                 input  busy, done, sel_zero, mask_home);
   modport seq  (input  start, abort, kind, decel_sw, home_sw,
                 index_p, decel_done,
                 output busy, done, sel_zero, mask_home);
endinterface

// *** pin_sync.sv ***
/*
 * Two-flop synchroniser for asynchronous pin levels.
 * Assumes no pulse narrower than two clocks.
 */
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   // Pins and synchronised levels
   input  wire logic [W-1:0] pins_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // Refuse an empty group
   if (W < 1) begin : g_check
      $error("pin_sync needs at least one pin");
   end

   // First stage is read only by the second
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= pins_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** homing_seq.sv ***
/*
 * Homing sequencer: switch search, slow-down, zero search, index.
 * Assumes synchronised pins and a same-clock slow-down done level.
 */
`timescale 1ns/1ps
module homing_seq
   import servo_stop_pkg::*;
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Link to the parameter block
   homing_if.seq     hs
);
   home_state_t state_q;
   home_kind_t  kind_q;
   logic        decel_prev_q;
   logic        home_prev_q;
   logic        index_prev_q;
   logic        decel_rise;
   logic        home_rise;
   logic        index_rise;

   // Edge detection
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         decel_prev_q <= 1'b0;
         home_prev_q  <= 1'b0;
         index_prev_q <= 1'b0;
      end else begin
         decel_prev_q <= hs.decel_sw;
         home_prev_q  <= hs.home_sw;
         index_prev_q <= hs.index_p;
      end
   end

   assign decel_rise = hs.decel_sw & ~decel_prev_q;
   assign home_rise  = hs.home_sw & ~home_prev_q;
   assign index_rise = hs.index_p & ~index_prev_q;

   // Homing state machine
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q <= ST_IDLE;
         kind_q  <= KIND_NONE;
      end else if (hs.abort) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE, ST_DONE: begin
               if (hs.start) begin
                  kind_q <= hs.kind;
                  case (hs.kind)
                     KIND_STD, KIND_COINCIDE: state_q <= ST_SEEK_DEC;
                     KIND_INDEX:              state_q <= ST_SEEK_INDEX; // RULE13
                     KIND_HERE:               state_q <= ST_DONE; // RULE13
                     default:                 state_q <= state_q;
                  endcase
               end
            end
            ST_SEEK_DEC: begin
               if (decel_rise) begin
                  state_q <= ST_DECEL;
               end
            end
            ST_DECEL: begin
               // Home pin ignored here
               if (hs.decel_done) begin
                  state_q <= ST_SEEK_HOME; // RULE12
               end
            end
            ST_SEEK_HOME: begin
               if (home_rise) begin
                  // Coinciding kind ends at home
                  state_q <= (kind_q == KIND_COINCIDE) ? ST_DONE
                                                       : ST_SEEK_INDEX; // RULE14
               end
            end
            ST_SEEK_INDEX: begin
               if (index_rise) begin
                  state_q <= ST_DONE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Status
   assign hs.busy      = ~(state_q == ST_IDLE || state_q == ST_DONE);
   assign hs.done      = (state_q == ST_DONE);
   assign hs.sel_zero  = (state_q == ST_SEEK_HOME ||
                          state_q == ST_SEEK_INDEX);
   assign hs.mask_home = (state_q == ST_DECEL); // RULE12
endmodule

// *** servo_stop_homing_params.sv ***
/*
 * Stop and homing objects of a servo drive,
 * with stop selection and the homing sequencer.
 * Assumes object access and drive state on clk_in,
 * and the three homing pins
 * asynchronous to it.
 */
`timescale 1ns/1ps

// Behaviour
// RULE1: Quick stop with option 2/5 uses stored deceleration
// RULE2: Zero written to deceleration or slope becomes one
// RULE3: Profile type accepts only zero, linear
// RULE4: Torque slope, unsigned 32 bits, defaults all ones
// RULE5: Torque modes ramp down on listed stop codes
// RULE6: Slope above torque limit is clamped to limit
// RULE7: Methods 15, 16, 31, 32 do no homing
// RULE8: Homing speeds object holds two sub-entries
// RULE9: Switch search speed, 32 bits, defaults 100
// RULE10: Host should set a large switch speed
// RULE11: Zero search speed defaults 10, used near home
// RULE12: Home pin ignored while decelerating after switch
// RULE13: 33/34 seek index reverse/forward, 35 here
// RULE14: Methods 17-30 follow 1-14, home at point
module servo_stop_homing_params
   import servo_stop_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   // Object dictionary access
   input  wire logic        od_req_in,
   input  wire logic        od_wr_in,
   input  wire logic [15:0] od_index_in,
   input  wire logic [7:0]  od_sub_in,
   input  wire logic [31:0] od_wdata_in,
   output logic             od_ack_out,
   output logic             od_abort_out,
   output logic      [31:0] od_rdata_out,
   // Drive state from the same clock
   input  wire logic [15:0] control_word_in,
   input  wire logic [15:0] qs_option_in,
   input  wire logic [15:0] halt_option_in,
   input  wire logic        halt_in,
   input  wire logic        torque_mode_in,
   input  wire logic [31:0] torque_limit_in,
   input  wire logic        homing_start_in,
   input  wire logic        decel_done_in,
   // Homing pins, asynchronous
   input  wire logic        decel_sw_in,
   input  wire logic        home_sw_in,
   input  wire logic        index_in,
   // Stop controls
   output logic             qs_decel_active_out,
   output logic      [31:0] stop_decel_out,
   output logic             torque_ramp_stop_out,
   output logic      [31:0] torque_slope_eff_out,
   // Homing controls and status
   output logic             homing_busy_out,
   output logic             homing_done_out,
   output logic             homing_ignored_out,
   output logic      [31:0] home_speed_out,
   output logic             home_fwd_out,
   output logic             home_mask_out
);
   localparam int PIN_W = 3;

   homing_if hs ();

   // Stored objects
   logic [31:0] qs_decel_q;
   logic [15:0] profile_type_q;
   logic [31:0] torque_slope_q;
   logic [7:0]  home_method_q;
   logic [31:0] switch_speed_q;
   logic [31:0] zero_speed_q;
   // Access decode
   logic        wr_ok;
   logic        rd_ok;
   logic [31:0] rd_val;
   // Stop decode
   logic        qs_req;
   logic        qs_opt_decel;
   logic        qs_opt_torque;
   logic        halt_opt_torque;
   // Homing command
   logic        start_q;
   logic        fwd_q;
   home_kind_t  kind_q;
   logic [PIN_W-1:0] pins_sync;

   // Zero is never stored as a deceleration or a torque slope
   function automatic logic [31:0] no_zero(input logic [31:0] v);
      no_zero = (v == '0) ? ZERO_SUBSTITUTE : v; // RULE2
   endfunction

   // Method code to kind of run
   function automatic home_kind_t method_kind(input logic [7:0] m);
      if (m >= METHOD_STD_FIRST && m <= METHOD_STD_LAST) begin
         method_kind = KIND_STD;
      end else if (m >= METHOD_CO_FIRST && m <= METHOD_CO_LAST) begin
         method_kind = KIND_COINCIDE; // RULE14
      end else if (m == METHOD_INDEX_REV || m == METHOD_INDEX_FWD) begin
         method_kind = KIND_INDEX; // RULE13
      end else if (m == METHOD_HERE) begin
         method_kind = KIND_HERE; // RULE13
      end else begin
         method_kind = KIND_NONE; // RULE7
      end
   endfunction

   // Search direction of a method code
   function automatic logic method_fwd(input logic [7:0] m);
      logic [7:0] base;
      base = m;
      if (m >= METHOD_CO_FIRST && m <= METHOD_CO_LAST) begin
         base = m - METHOD_CO_OFFSET; // RULE14
      end
      if (m == METHOD_INDEX_FWD) begin
         method_fwd = 1'b1; // RULE13
      end else if (base >= METHOD_STD_FIRST && base <= METHOD_STD_LAST)
      begin
         method_fwd = HOME_FWD_MASK[4'(base - METHOD_STD_FIRST)];
      end else begin
         method_fwd = 1'b0;
      end
   endfunction

   // Pin synchroniser
   pin_sync #(
      .W         (PIN_W)
   ) u_sync (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .pins_in   ({index_in, home_sw_in, decel_sw_in}),
      .sync_out  (pins_sync)
   );

   // Homing sequencer
   homing_seq u_seq (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .hs        (hs.seq)
   );

   // Write acceptance per object
   always_comb begin
      wr_ok = 1'b0;
      case (od_index_in)
         IDX_QS_DECEL:     wr_ok = (od_sub_in == SUB_COUNT);
         IDX_TORQUE_SLOPE: wr_ok = (od_sub_in == SUB_COUNT);
         IDX_PROFILE_TYPE: wr_ok = (od_sub_in == SUB_COUNT) &&
                                   (od_wdata_in[15:0] == PROFILE_LINEAR); // RULE3
         IDX_HOME_METHOD:  wr_ok = (od_sub_in == SUB_COUNT) &&
                                   (od_wdata_in[7:0] <= METHOD_MAX);
         IDX_HOME_SPEEDS:  wr_ok = (od_sub_in == SUB_SWITCH_SPEED) ||
                                   (od_sub_in == SUB_ZERO_SPEED);
         default:          wr_ok = 1'b0;
      endcase
   end

   // Read mux, narrow objects low
   always_comb begin
      rd_ok  = 1'b1;
      rd_val = '0;
      case (od_index_in)
         IDX_QS_DECEL:     rd_val = qs_decel_q;
         IDX_PROFILE_TYPE: rd_val = {16'h0000, profile_type_q};
         IDX_TORQUE_SLOPE: rd_val = torque_slope_q;
         IDX_HOME_METHOD:  rd_val = {24'h000000, home_method_q};
         IDX_HOME_SPEEDS: begin
            case (od_sub_in)
               SUB_COUNT:        rd_val = {24'h000000, HOME_SPEED_COUNT}; // RULE8
               SUB_SWITCH_SPEED: rd_val = switch_speed_q;
               SUB_ZERO_SPEED:   rd_val = zero_speed_q;
               default:          rd_ok  = 1'b0;
            endcase
         end
         default:          rd_ok = 1'b0;
      endcase
      if (od_index_in != IDX_HOME_SPEEDS && od_sub_in != SUB_COUNT) begin
         rd_ok = 1'b0;
      end
   end

   // Object storage
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         qs_decel_q     <= QS_DECEL_RST; // RULE1
         profile_type_q <= PROFILE_TYPE_RST; // RULE3
         torque_slope_q <= TORQUE_SLOPE_RST; // RULE4
         home_method_q  <= HOME_METHOD_RST;
         switch_speed_q <= SWITCH_SPEED_RST; // RULE9
         zero_speed_q   <= ZERO_SPEED_RST; // RULE11
      end else if (od_req_in && od_wr_in && wr_ok) begin
         case (od_index_in)
            IDX_QS_DECEL:     qs_decel_q     <= no_zero(od_wdata_in); // RULE2
            IDX_PROFILE_TYPE: profile_type_q <= od_wdata_in[15:0];
            IDX_TORQUE_SLOPE: torque_slope_q <= no_zero(od_wdata_in); // RULE2
            IDX_HOME_METHOD:  home_method_q  <= od_wdata_in[7:0];
            IDX_HOME_SPEEDS: begin
               if (od_sub_in == SUB_SWITCH_SPEED) begin
                  switch_speed_q <= od_wdata_in; // RULE9
               end else begin
                  zero_speed_q <= od_wdata_in; // RULE11
               end
            end
            default: qs_decel_q <= qs_decel_q;
         endcase
      end
   end

   // Access answer
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         od_ack_out   <= 1'b0;
         od_abort_out <= 1'b0;
         od_rdata_out <= '0;
      end else begin
         od_ack_out   <= od_req_in;
         od_abort_out <= od_req_in && (od_wr_in ? !wr_ok : !rd_ok);
         if (od_req_in && !od_wr_in && rd_ok) begin
            od_rdata_out <= rd_val;
         end
      end
   end

   // Stop request decode
   assign qs_req          = (control_word_in == CW_QUICK_STOP);
   assign qs_opt_decel    = (qs_option_in == OPT_CODE_2) ||
                            (qs_option_in == OPT_CODE_5);
   assign qs_opt_torque   = (qs_option_in == OPT_CODE_1) ||
                            (qs_option_in == OPT_CODE_2) ||
                            (qs_option_in == OPT_CODE_5) ||
                            (qs_option_in == OPT_CODE_6);
   assign halt_opt_torque = (halt_option_in == OPT_CODE_1) ||
                            (halt_option_in == OPT_CODE_2);

   // Stop deceleration selection
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         qs_decel_active_out <= 1'b0;
         stop_decel_out      <= QS_DECEL_RST;
      end else begin
         qs_decel_active_out <= qs_req && qs_opt_decel; // RULE1
         stop_decel_out      <= qs_decel_q; // RULE1
      end
   end

   // Torque-mode ramp stop and slope limit
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         torque_ramp_stop_out <= 1'b0;
         torque_slope_eff_out <= '0;
      end else begin
         torque_ramp_stop_out <= torque_mode_in &&
                                 ((qs_req && qs_opt_torque) ||
                                  (halt_in && halt_opt_torque)); // RULE5
         torque_slope_eff_out <= (torque_slope_q > torque_limit_in) ?
                                 torque_limit_in : torque_slope_q; // RULE6
      end
   end

   // Homing start gating
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         start_q            <= 1'b0;
         kind_q             <= KIND_NONE;
         fwd_q              <= 1'b0;
         homing_ignored_out <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (homing_start_in && !hs.busy) begin
            kind_q <= method_kind(home_method_q);
            fwd_q  <= method_fwd(home_method_q);
            if (method_kind(home_method_q) == KIND_NONE) begin
               homing_ignored_out <= 1'b1; // RULE7
            end else begin
               homing_ignored_out <= 1'b0;
               start_q            <= 1'b1;
            end
         end
      end
   end

   // Sequencer command and pin levels
   assign hs.start      = start_q;
   assign hs.abort      = qs_req || halt_in;
   assign hs.kind       = kind_q;
   assign hs.decel_sw   = pins_sync[0];
   assign hs.home_sw    = pins_sync[1];
   assign hs.index_p    = pins_sync[2];
   assign hs.decel_done = decel_done_in;

   // Speed reference
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         home_speed_out <= '0;
         home_fwd_out   <= 1'b0;
      end else begin
         home_fwd_out <= fwd_q;
         if (!hs.busy) begin
            home_speed_out <= '0;
         end else if (hs.sel_zero) begin
            home_speed_out <= zero_speed_q; // RULE11
         end else begin
            home_speed_out <= switch_speed_q; // RULE9
         end
      end
   end

   // Homing status
   assign homing_busy_out = hs.busy;
   assign homing_done_out = hs.done;
   assign home_mask_out   = hs.mask_home;
endmodule

// *** servo_stop_homing_monitor.sv ***
/*
 * Port checks on the stop and homing block.
 * Assumes clk_in and synchronous active-low resetn_in.
 */
`timescale 1ns/1ps
module servo_stop_homing_monitor (
   // Clock, reset and object access
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        od_req_in,
   input wire logic        od_wr_in,
   input wire logic [15:0] od_index_in,
   input wire logic [7:0]  od_sub_in,
   input wire logic [31:0] od_wdata_in,
   input wire logic        od_ack_out,
   input wire logic        od_abort_out,
   // Drive state and outputs
   input wire logic [15:0] control_word_in,
   input wire logic [15:0] qs_option_in,
   input wire logic [15:0] halt_option_in,
   input wire logic        halt_in,
   input wire logic        torque_mode_in,
   input wire logic [31:0] torque_limit_in,
   input wire logic        qs_decel_active_out,
   input wire logic        torque_ramp_stop_out,
   input wire logic [31:0] torque_slope_eff_out,
   input wire logic        homing_busy_out,
   input wire logic        homing_done_out,
   input wire logic        home_mask_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Refused writes
   sequence s_bad_profile;
      od_req_in && od_wr_in && od_index_in == 16'h6086
         && od_wdata_in[15:0] != 16'h0000;
   endsequence
   sequence s_bad_method;
      od_req_in && od_wr_in && od_index_in == 16'h6098
         && od_wdata_in[7:0] > 8'h23;
   endsequence
   a_ack_follows_req: assert property (od_req_in |=> od_ack_out)
      else $error("ack missing");
   a_no_stray_ack: assert property (!od_req_in |=> !od_ack_out)
      else $error("stray ack");
   a_profile_refuse: assert property (s_bad_profile |=> od_abort_out)
      else $error("bad profile taken");
   a_method_range: assert property (s_bad_method |=> od_abort_out)
      else $error("bad method taken");
   a_count_ro: assert property (od_req_in && od_wr_in && od_sub_in == 8'h00
      && od_index_in == 16'h6099 |=> od_abort_out)
      else $error("count write taken");
   a_qs_decode: assert property (qs_decel_active_out ==
      $past(control_word_in == 16'h0002
      && (qs_option_in == 16'h0002 || qs_option_in == 16'h0005)))
      else $error("qs select wrong");
   a_torque_clamp: assert property (torque_slope_eff_out
      <= $past(torque_limit_in))
      else $error("slope over limit");
   a_halt_ramp: assert property (torque_mode_in && halt_in
      && (halt_option_in == 16'h0001 || halt_option_in == 16'h0002)
      |=> torque_ramp_stop_out)
      else $error("no halt ramp");
   a_mask_in_busy: assert property (home_mask_out |->
      homing_busy_out && !homing_done_out)
      else $error("stray mask");
   a_qs_abort: assert property (homing_busy_out
      && control_word_in == 16'h0002 |=> !homing_busy_out)
      else $error("qs kept homing");
endmodule
bind servo_stop_homing_params servo_stop_homing_monitor u_mon (.*);

// *** od_host_model.sv ***
/*
 * Fieldbus host model: issues one-cycle object requests to the block.
 * Assumes the ack arrives one cycle after the request is taken.
 */
`timescale 1ns/1ps
module od_host_model (
   // Clock and answer
   input  wire logic        clk_in,
   input  wire logic        od_ack_in,
   input  wire logic        od_abort_in,
   input  wire logic [31:0] od_rdata_in,
   // Request
   output logic             od_req_out,
   output logic             od_wr_out,
   output logic      [15:0] od_index_out,
   output logic      [7:0]  od_sub_out,
   output logic      [31:0] od_wdata_out
);
   // Idle bus at time zero
   initial begin
      {od_req_out, od_wr_out, od_index_out} = '0;
      {od_sub_out, od_wdata_out} = '0;
   end
   // One access, answer taken at the ack edge
   task automatic xfer(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] wd,
      output logic [31:0] rd, output logic ab);
      @(posedge clk_in);
      od_req_out   <= 1'b1;
      od_wr_out    <= wr;
      od_index_out <= idx;
      od_sub_out   <= sub;
      od_wdata_out <= wd;
      @(posedge clk_in);
      od_req_out   <= 1'b0;
      @(posedge clk_in);
      rd = od_rdata_in;
      ab = od_abort_in | ~od_ack_in;
   endtask
endmodule

// *** tb_servo_stop_homing_params.sv ***
/*
 * Self-checking bench for the stop and homing block.
 * Assumes the host model for object access.
 */
`timescale 1ns/1ps
module tb_servo_stop_homing_params;
   import servo_stop_pkg::*;
   logic clk, resetn, req, wr, ack, abt, halt, tmode, hstart, ddone;
   logic dsw, hsw, idx, qsa, trs, busy, hdone, ign, fwd, mask;
   logic [15:0] index, cw, qso, hlo;
   logic [7:0]  sub;
   logic [31:0] wdata, rdata, tlim, sdec, tse, hspd;
   int errors, n_compared;
   logic [15:0] di[7] = '{16'h6085, 16'h6086, 16'h6087, 16'h6098,
                          16'h6099, 16'h6099, 16'h6099};
   logic [31:0] dv[7] = '{32'h7FFFFFFF, 32'h0, 32'hFFFFFFFF, 32'h1,
                          32'h2, 32'h64, 32'hA};
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   servo_stop_homing_params servo_stop_homing_params_inst (.clk_in(clk),
      .resetn_in(resetn), .od_req_in(req), .od_wr_in(wr),
      .od_index_in(index), .od_sub_in(sub), .od_wdata_in(wdata),
      .od_ack_out(ack), .od_abort_out(abt), .od_rdata_out(rdata),
      .control_word_in(cw), .qs_option_in(qso), .halt_option_in(hlo),
      .halt_in(halt), .torque_mode_in(tmode), .torque_limit_in(tlim),
      .homing_start_in(hstart), .decel_done_in(ddone), .decel_sw_in(dsw),
      .home_sw_in(hsw), .index_in(idx), .qs_decel_active_out(qsa),
      .stop_decel_out(sdec), .torque_ramp_stop_out(trs),
      .torque_slope_eff_out(tse), .homing_busy_out(busy),
      .homing_done_out(hdone), .homing_ignored_out(ign),
      .home_speed_out(hspd), .home_fwd_out(fwd), .home_mask_out(mask));
   od_host_model od_host_model_inst (.clk_in(clk), .od_ack_in(ack),
      .od_abort_in(abt), .od_rdata_in(rdata), .od_req_out(req),
      .od_wr_out(wr), .od_index_out(index), .od_sub_out(sub),
      .od_wdata_out(wdata));
   // Comparisons
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Object access
   task automatic wr_obj(input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, input logic exp_ab);
      logic [31:0] r;
      logic a;
      od_host_model_inst.xfer(1'b1, i, s, d, r, a);
      chk1(a, exp_ab);
   endtask
   task automatic rd_obj(input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] exp);
      logic [31:0] r;
      logic a;
      od_host_model_inst.xfer(1'b0, i, s, 32'h0, r, a);
      chk1(a, 1'b0);
      chk32(r, exp);
   endtask
   task automatic start_home(input logic [7:0] m);
      wr_obj(16'h6098, 8'h00, {24'h0, m}, 1'b0);
      @(posedge clk) hstart <= 1'b1;
      @(posedge clk) hstart <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      step(20000);
      errors++;
      tally_and_finish;
   end
   // Test sequence
   initial begin
      {resetn, halt, tmode, hstart, ddone, dsw, hsw, idx} = 8'h00;
      {cw, qso, hlo, tlim} = 80'h0;
      errors = 0;
      n_compared = 0;
      step(5);
      resetn <= 1'b1;
      for (int k = 0; k < 7; k++)
         rd_obj(di[k], (k < 4) ? 8'h00 : 8'(k - 4), dv[k]);
      $display("test defaults done");
      wr_obj(16'h6085, 8'h00, 32'h0, 1'b0);
      rd_obj(16'h6085, 8'h00, 32'h1);
      wr_obj(16'h6087, 8'h00, 32'h0, 1'b0);
      rd_obj(16'h6087, 8'h00, 32'h1);
      wr_obj(16'h6086, 8'h00, 32'h5, 1'b1);
      rd_obj(16'h6086, 8'h00, 32'h0);
      wr_obj(16'h6099, 8'h00, 32'h3, 1'b1);
      rd_obj(16'h6099, 8'h00, 32'h2);
      wr_obj(16'h6099, 8'h03, 32'h3, 1'b1);
      wr_obj(16'h6084, 8'h00, 32'h3, 1'b1);
      wr_obj(16'h6098, 8'h00, 32'h24, 1'b1);
      $display("test objects done");
      wr_obj(16'h6085, 8'h00, 32'h1234, 1'b0);
      cw <= 16'h0002;
      qso <= 16'h0005;
      step(3);
      chk1(qsa, 1'b1);
      chk32(sdec, 32'h1234);
      qso <= 16'h0001;
      tmode <= 1'b1;
      step(3);
      chk1(qsa, 1'b0);
      foreach (dv[k]) if (k < 4) begin
         qso <= 16'(1 + k % 2 + 4 * (k / 2));
         step(3);
         chk1(trs, 1'b1);
      end
      cw <= 16'h0000;
      halt <= 1'b1;
      hlo <= 16'h0002;
      step(3);
      chk1(trs, 1'b1);
      hlo <= 16'h0003;
      step(3);
      chk1(trs, 1'b0);
      {halt, tmode} <= 2'b00;
      wr_obj(16'h6087, 8'h00, 32'h1F4, 1'b0);
      tlim <= 32'h12C;
      step(3);
      chk32(tse, 32'h12C);
      tlim <= 32'h3E8;
      step(3);
      chk32(tse, 32'h1F4);
      $display("test stop done");
      foreach (dv[k]) if (k < 4) begin
         start_home(8'(15 + k % 2 + 16 * (k / 2)));
         step(2);
         chk1(ign, 1'b1);
         chk1(busy, 1'b0);
      end
      start_home(8'd35);
      step(3);
      chk1(hdone, 1'b1);
      wr_obj(16'h6099, 8'h01, 32'h10000, 1'b0);
      start_home(8'd17);
      step(3);
      chk1(busy, 1'b1);
      chk32(hspd, 32'h10000);
      chk1(fwd, 1'b0);
      dsw <= 1'b1;
      step(5);
      chk1(mask, 1'b1);
      hsw <= 1'b1;
      step(5);
      hsw <= 1'b0;
      step(5);
      chk1(busy, 1'b1);
      ddone <= 1'b1;
      step(5);
      chk32(hspd, 32'hA);
      hsw <= 1'b1;
      step(5);
      chk1(hdone, 1'b1);
      {dsw, hsw, ddone} <= 3'b000;
      start_home(8'd34);
      step(3);
      chk1(fwd, 1'b1);
      idx <= 1'b1;
      step(5);
      chk1(hdone, 1'b1);
      idx <= 1'b0;
      start_home(8'd1);
      step(3);
      cw <= 16'h0002;
      step(3);
      chk1(busy, 1'b0);
      $display("test homing done");
      tally_and_finish;
   end
endmodule
